// ### design/sffp_pkg.sv
// Package with register map, field positions and constants of the feed-forward path
package sffp_pkg;
    // APB register byte offsets
    localparam logic [7:0] VFF_GAIN_OFS = 8'h00;
    localparam logic [7:0] VFF_FILT_OFS = 8'h04;
    localparam logic [7:0] TFF_GAIN_OFS = 8'h08;
    localparam logic [7:0] TFF_FILT_OFS = 8'h0c;
    localparam logic [7:0] ATFF_GAIN_OFS = 8'h10;
    localparam logic [7:0] FUNC_EXP_OFS = 8'h14;
    localparam logic [7:0] CTRL_MODE_OFS = 8'h18;
    localparam logic [7:0] AUTOTUNE_OFS = 8'h1c;
    localparam logic [7:0] INERTIA_OFS = 8'h20;
    localparam logic [7:0] STATUS_OFS = 8'h24;
    // Reset values
    localparam logic [15:0] VFF_GAIN_RST = 16'h0000;
    localparam logic [15:0] VFF_FILT_RST = 16'h0000;
    localparam logic [15:0] TFF_GAIN_RST = 16'h0000;
    localparam logic [15:0] TFF_FILT_RST = 16'h0000;
    localparam logic [15:0] ATFF_GAIN_RST = 16'h0000;
    localparam logic [15:0] FUNC_EXP_RST = 16'h0000;
    localparam logic [15:0] CTRL_MODE_RST = 16'h0000;
    localparam logic [15:0] AUTOTUNE_RST = 16'h0001;
    localparam logic [15:0] INERTIA_RST = 16'h0064;
    // Field positions
    localparam int FX_OBS_BIT = 0;
    localparam int FX_ATFF_BIT = 5;
    localparam int ST_FF_BIT = 0;
    localparam int ST_ATFF_BIT = 1;
    localparam int ST_OBS_BIT = 2;
    localparam int ST_SAT_BIT = 3;
    // Control mode codes
    localparam logic [15:0] MODE_POS = 16'h0000;
    localparam logic [15:0] MODE_VEL = 16'h0001;
    localparam logic [15:0] MODE_POS_VEL = 16'h0003;
    localparam logic [15:0] MODE_POS_TRQ = 16'h0004;
    localparam logic [15:0] MODE_FULL = 16'h0006;
    // Gains in 0.1 % steps, full ratio is 1000
    localparam int GAIN_SCALE = 1000;
    localparam logic [15:0] GAIN_MAX = 16'h03e8;
    // Lowest valid analog conversion gain
    localparam logic [15:0] ATFF_GAIN_MIN = 16'h000a;
    // Analog: torque [0.1 %] = 10 * mV / gain, i.e. 100 * V / (gain * 0.1)
    localparam int ATFF_MV_NUM = 10;
    // Filter units: 50 means 0.5 ms, so one unit is 10 us
    localparam int FILT_UNIT_NS = 10000;
    localparam int FILT_REF_SET = 50;
    localparam int FILT_REF_US = 500;
    // Clock
    localparam int PCLK_PERIOD_NS = 40;
    // Parameter block carried to the datapath
    typedef struct packed {
        logic [15:0] vff_gain;
        logic [15:0] vff_filt;
        logic [15:0] tff_gain;
        logic [15:0] tff_filt;
        logic [15:0] atff_gain;
        logic [15:0] func_exp;
        logic [15:0] ctrl_mode;
        logic [15:0] autotune;
        logic [15:0] inertia;
    } sffp_cfg_type;
    // Status flags
    typedef struct packed {
        logic tq_sat;
        logic obs_act;
        logic atff_act;
        logic ff_act;
    } sffp_stat_type;
endpackage : sffp_pkg

// ### design/sffp_top.sv
// Servo feed-forward datapath with APB parameter registers
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Velocity and torque feed forward act only in position or full-closed control; analog torque feed forward acts in any mode.
// - Filtered velocity feed forward times gain is added to position-loop speed command.
// - Velocity feed-forward input passes a first-order lag set by its filter register.
// - Filtered torque feed forward times gain is added to velocity-loop torque command.
// - Torque feed-forward input passes a first-order lag set by its filter register.
// - Filter setting unit is 10 us, so 50 means 0.5 ms.
// - Analog conversion gain 0 to 9 disables analog torque feed forward.
// - Expansion bit 5 enables analog torque feed forward.
// - Analog input 3 used by another function disables analog feed forward.
// - Analog torque percent is 100*V/(gain*0.1), signed by voltage polarity.
// - Active observer estimates motor speed with a load model.
// - Observer acts only in control mode 0 or 1.
// - Observer acts only at servo on with real-time auto-tuning set to 0.
// - Expansion bit 0 enables the instantaneous speed observer.
module sffp_top
#(
    parameter int CMD_W = 24,
    parameter int TQ_W = 16,
    parameter int CYCLE_UNITS = 2,
    parameter int OBS_TQ_SHIFT = 4,
    parameter int OBS_CORR_SHIFT = 3,
    parameter logic [15:0] TQ_LIMIT = 16'h0bb8
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control cycle and loop commands from same-clock logic
    input wire logic ctrl_tick,
    input wire logic signed [CMD_W-1:0] pos_cmd_velocity,
    input wire logic signed [CMD_W-1:0] pos_loop_speed,
    input wire logic signed [CMD_W-1:0] vel_cmd_torque,
    input wire logic signed [TQ_W-1:0] vel_loop_torque,
    input wire logic signed [15:0] ain3_mv,
    input wire logic signed [CMD_W-1:0] measured_speed,
    // Pins, asynchronous
    input wire logic servo_on,
    input wire logic ain3_other_use,
    input wire logic mode_second_sel,
    // Results
    output logic signed [CMD_W-1:0] speed_cmd_q,
    output logic signed [TQ_W-1:0] torque_cmd_q,
    output logic signed [CMD_W-1:0] speed_est_q,
    output logic observer_active
);
    import sffp_pkg::*;

    localparam int AW = CMD_W + 18;
    localparam logic [15:0] CYC_U = 16'(CYCLE_UNITS);
    // Signed clip bounds; unsigned ones would make negative sums look huge
    localparam logic signed [AW-1:0] SPD_MAX = AW'({1'b0, {(CMD_W-1){1'b1}}});
    localparam logic signed [AW-1:0] TQ_MAX = AW'(TQ_LIMIT);
    // Control cycle length in ns, informative
    localparam int CYCLE_NS = CYCLE_UNITS * FILT_UNIT_NS;

    sffp_cfg_type cfg_q;
    sffp_stat_type stat_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic signed [CMD_W-1:0] vff_filt_q;
    logic signed [CMD_W-1:0] tff_filt_q;
    logic signed [TQ_W+1:0] atff_tq_q;
    logic signed [AW-1:0] speed_sum;
    logic signed [AW-1:0] tq_sum;
    logic signed [AW-1:0] vff_term;
    logic signed [AW-1:0] tff_term;
    logic [4:0] vff_shift;
    logic [4:0] tff_shift;
    logic ff_en;
    logic atff_en;
    logic obs_en;
    logic servo_on_s;
    logic ain3_other_s;
    logic mode_sel_s;
    logic bus_wr;
    logic addr_hit;

    // Number of significant bits; lag coefficient is 2^-bits of tau/cycle
    function automatic logic [4:0] sffp_bitlen(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++)
        begin
            if (v[i])
            begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction : sffp_bitlen

    // Two-stage synchronisers for the pin inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {mode_second_sel, ain3_other_use, servo_on};
            sync2_q <= sync1_q;
        end
    end
    assign servo_on_s = sync2_q[0];
    assign ain3_other_s = sync2_q[1];
    assign mode_sel_s = sync2_q[2];

    // APB decode; zero wait states, unmapped offsets answer with pslverr
    always_comb
    begin
        addr_hit = (paddr <= STATUS_OFS) && (paddr[1:0] == 2'h0);
        prdata = 32'h0000_0000;
        case (paddr)
            VFF_GAIN_OFS: prdata = {16'h0000, cfg_q.vff_gain};
            VFF_FILT_OFS: prdata = {16'h0000, cfg_q.vff_filt};
            TFF_GAIN_OFS: prdata = {16'h0000, cfg_q.tff_gain};
            TFF_FILT_OFS: prdata = {16'h0000, cfg_q.tff_filt};
            ATFF_GAIN_OFS: prdata = {16'h0000, cfg_q.atff_gain};
            FUNC_EXP_OFS: prdata = {16'h0000, cfg_q.func_exp};
            CTRL_MODE_OFS: prdata = {16'h0000, cfg_q.ctrl_mode};
            AUTOTUNE_OFS: prdata = {16'h0000, cfg_q.autotune};
            INERTIA_OFS: prdata = {16'h0000, cfg_q.inertia};
            STATUS_OFS: prdata = {28'h0000000, stat_q};
            default: prdata = 32'h0000_0000;
        endcase
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign bus_wr = psel && penable && pwrite;

    // Parameter registers; status is read only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= '{VFF_GAIN_RST, VFF_FILT_RST, TFF_GAIN_RST, TFF_FILT_RST, ATFF_GAIN_RST,
                       FUNC_EXP_RST, CTRL_MODE_RST, AUTOTUNE_RST, INERTIA_RST};
        end
        else if (bus_wr)
        begin
            case (paddr)
                VFF_GAIN_OFS: cfg_q.vff_gain <= pwdata[15:0];
                VFF_FILT_OFS: cfg_q.vff_filt <= pwdata[15:0];
                TFF_GAIN_OFS: cfg_q.tff_gain <= pwdata[15:0];
                TFF_FILT_OFS: cfg_q.tff_filt <= pwdata[15:0];
                ATFF_GAIN_OFS: cfg_q.atff_gain <= pwdata[15:0];
                FUNC_EXP_OFS: cfg_q.func_exp <= pwdata[15:0];
                CTRL_MODE_OFS: cfg_q.ctrl_mode <= pwdata[15:0];
                AUTOTUNE_OFS: cfg_q.autotune <= pwdata[15:0];
                INERTIA_OFS: cfg_q.inertia <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Enables; switching modes count as position while the mode pin is low
    always_comb
    begin
        ff_en = 1'b0;
        case (cfg_q.ctrl_mode)
            MODE_POS, MODE_FULL: ff_en = 1'b1;
            MODE_POS_VEL, MODE_POS_TRQ: ff_en = !mode_sel_s;
            default: ff_en = 1'b0;
        endcase
        atff_en = cfg_q.func_exp[FX_ATFF_BIT]
                  && (cfg_q.atff_gain >= ATFF_GAIN_MIN)
                  && !ain3_other_s;
        obs_en = cfg_q.func_exp[FX_OBS_BIT]
                 && ((cfg_q.ctrl_mode == MODE_POS) || (cfg_q.ctrl_mode == MODE_VEL))
                 && servo_on_s && (cfg_q.autotune == 16'h0000);
    end
    assign observer_active = obs_en;

    // Lag coefficient from tau in 10 us units over the control cycle
    assign vff_shift = sffp_bitlen(cfg_q.vff_filt / CYC_U);
    assign tff_shift = sffp_bitlen(cfg_q.tff_filt / CYC_U);

    // First-order lag filters on both feed-forward inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vff_filt_q <= '0;
            tff_filt_q <= '0;
        end
        else if (ctrl_tick)
        begin
            vff_filt_q <= vff_filt_q + CMD_W'((pos_cmd_velocity - vff_filt_q) >>> vff_shift);
            tff_filt_q <= tff_filt_q + CMD_W'((vel_cmd_torque - tff_filt_q) >>> tff_shift);
        end
    end

    // Gain products; gains above full ratio are clipped to keep sums bounded
    always_comb
    begin
        vff_term = (AW'(vff_filt_q) * AW'(signed'({1'b0, (cfg_q.vff_gain > GAIN_MAX) ?
                   GAIN_MAX : cfg_q.vff_gain}))) / AW'(GAIN_SCALE);
        tff_term = (AW'(tff_filt_q) * AW'(signed'({1'b0, (cfg_q.tff_gain > GAIN_MAX) ?
                   GAIN_MAX : cfg_q.tff_gain}))) / AW'(GAIN_SCALE);
        if (!ff_en)
        begin
            vff_term = '0;
            tff_term = '0;
        end
        speed_sum = AW'(pos_loop_speed) + vff_term;
        tq_sum = AW'(vel_loop_torque) + tff_term + AW'(atff_tq_q);
    end

    // Analog feed forward; the divider is large but runs once per cycle only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            atff_tq_q <= '0;
        end
        else if (!atff_en)
        begin
            atff_tq_q <= '0;
        end
        else if (ctrl_tick)
        begin
            atff_tq_q <= (TQ_W+2)'((32'(ain3_mv) * ATFF_MV_NUM)
                         / signed'({16'h0000, cfg_q.atff_gain}));
        end
    end

    // Output commands, speed clipped to its width and torque to the limit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            speed_cmd_q <= '0;
            torque_cmd_q <= '0;
            stat_q <= '0;
        end
        else if (ctrl_tick)
        begin
            speed_cmd_q <= (speed_sum > SPD_MAX) ? CMD_W'(SPD_MAX)
                           : (speed_sum < ~SPD_MAX) ? CMD_W'(~SPD_MAX) : CMD_W'(speed_sum);
            torque_cmd_q <= (tq_sum > TQ_MAX) ? TQ_W'(TQ_MAX)
                            : (tq_sum < -TQ_MAX) ? TQ_W'(-TQ_MAX) : TQ_W'(tq_sum);
            stat_q <= '{(tq_sum > TQ_MAX) || (tq_sum < -TQ_MAX), obs_en, atff_en, ff_en};
        end
    end

    // Load model: integrate torque, pull toward the encoder speed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            speed_est_q <= '0;
        end
        else if (!obs_en)
        begin
            speed_est_q <= measured_speed;
        end
        else if (ctrl_tick)
        begin
            speed_est_q <= speed_est_q + CMD_W'(torque_cmd_q >>> OBS_TQ_SHIFT)
                           + CMD_W'((measured_speed - speed_est_q) >>> OBS_CORR_SHIFT);
        end
    end

    // Checks
    ff_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && !ff_en |=> speed_cmd_q == $past(pos_loop_speed))
        else $error("speed feed forward leaked outside position modes");
    vff_unity_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && ff_en && cfg_q.vff_gain == 16'h0000 |=> speed_cmd_q == $past(pos_loop_speed))
        else $error("zero velocity gain changed the speed command");
    vff_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && cfg_q.vff_filt < CYC_U |=> vff_filt_q == $past(pos_cmd_velocity))
        else $error("velocity filter did not pass through");
    tff_unity_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && !ff_en && atff_tq_q == '0 && vel_loop_torque <= signed'({1'b0, TQ_LIMIT})
        && vel_loop_torque >= -signed'({1'b0, TQ_LIMIT}) |=> torque_cmd_q == $past(vel_loop_torque))
        else $error("torque feed forward leaked outside position modes");
    tff_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && cfg_q.tff_filt < CYC_U |=> tff_filt_q == $past(vel_cmd_torque))
        else $error("torque filter did not pass through");
    filt_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_q.vff_filt == 16'(FILT_REF_SET) && CYC_U == 16'h0002 |-> vff_shift == 5'h05)
        else $error("filter coefficient wrong for 0.5 ms");
    atff_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_q.atff_gain < ATFF_GAIN_MIN |=> atff_tq_q == '0)
        else $error("analog feed forward applied with invalid gain");
    atff_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_q.func_exp[FX_ATFF_BIT] |=> atff_tq_q == '0)
        else $error("analog feed forward applied while disabled");
    ain3_other_a: assert property (@(posedge pclk) disable iff (!presetn)
        ain3_other_s |=> atff_tq_q == '0)
        else $error("analog feed forward applied while input is reassigned");
    atff_sign_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && atff_en && ain3_mv > 16'sh0000
        && 32'(ain3_mv) * ATFF_MV_NUM >= 32'(cfg_q.atff_gain) |=> atff_tq_q > (TQ_W+2)'(0))
        else $error("positive voltage not added in CCW direction");
    obs_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !obs_en |=> speed_est_q == $past(measured_speed))
        else $error("estimate not tracking encoder when observer idle");
    obs_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_q.ctrl_mode > MODE_VEL |-> !observer_active)
        else $error("observer active in wrong control mode");
    obs_servo_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!servo_on_s || cfg_q.autotune != 16'h0000) |-> !observer_active)
        else $error("observer active without servo on or with auto-tuning");
    obs_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_q.func_exp[FX_OBS_BIT] |-> !observer_active)
        else $error("observer active while its bit is clear");
    tq_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
        torque_cmd_q <= signed'({1'b0, TQ_LIMIT}) && torque_cmd_q >= -signed'({1'b0, TQ_LIMIT}))
        else $error("torque command outside its range");
    ff_run_c: cover property (@(posedge pclk) disable iff (!presetn)
        ctrl_tick && ff_en && cfg_q.vff_gain != 16'h0000);
    atff_run_c: cover property (@(posedge pclk) disable iff (!presetn) ctrl_tick && atff_en);
    obs_run_c: cover property (@(posedge pclk) disable iff (!presetn) ctrl_tick && obs_en);
    tq_clip_c: cover property (@(posedge pclk) disable iff (!presetn) stat_q.tq_sat);
endmodule : sffp_top

// ### tb/sffp_host_model.sv
// Host-side model issuing control ticks and the internal velocity command
`timescale 1ns/1ps
module sffp_host_model
#(
    parameter int CMD_W = 24
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Requests from the bench
    input wire logic tick_en,
    input wire logic signed [CMD_W-1:0] vel_target,
    // Toward the block
    output logic ctrl_tick,
    output logic signed [CMD_W-1:0] pos_cmd_velocity
);
    // Tick every other cycle, so a stop request never leaves a stray pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_tick <= 1'b0;
        else
            ctrl_tick <= tick_en & ~ctrl_tick;
    end
    // Command refreshed each cycle; the block only samples it on a tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pos_cmd_velocity <= '0;
        else
            pos_cmd_velocity <= vel_target;
    end
endmodule : sffp_host_model

// ### tb/tb_sffp_top.sv
// Self-checking testbench of the servo feed-forward datapath
`timescale 1ns/1ps
module tb_sffp_top;
    import sffp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ctrl_tick;
    logic tick_en = 1'b0;
    logic signed [23:0] vel_target = 24'h0;
    logic signed [23:0] pos_cmd_velocity;
    logic signed [23:0] pos_loop_speed = 24'h0;
    logic signed [23:0] vel_cmd_torque = 24'h0;
    logic signed [15:0] vel_loop_torque = 16'h0;
    logic signed [15:0] ain3_mv = 16'h0;
    logic signed [23:0] measured_speed = 24'h0;
    logic servo_on = 1'b0;
    logic ain3_other_use = 1'b0;
    logic mode_second_sel = 1'b0;
    logic signed [23:0] speed_cmd_q;
    logic signed [15:0] torque_cmd_q;
    logic signed [23:0] speed_est_q;
    logic observer_active;
    int bad_count = 0;
    int cmp_count = 0;

    // 25 MHz control clock
    always #20 pclk = ~pclk;

    sffp_top u_sffp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl_tick(ctrl_tick), .pos_cmd_velocity(pos_cmd_velocity),
        .pos_loop_speed(pos_loop_speed), .vel_cmd_torque(vel_cmd_torque),
        .vel_loop_torque(vel_loop_torque), .ain3_mv(ain3_mv), .measured_speed(measured_speed),
        .servo_on(servo_on), .ain3_other_use(ain3_other_use),
        .mode_second_sel(mode_second_sel), .speed_cmd_q(speed_cmd_q),
        .torque_cmd_q(torque_cmd_q), .speed_est_q(speed_est_q),
        .observer_active(observer_active));

    sffp_host_model u_sffp_host_model (.pclk(pclk), .presetn(presetn), .tick_en(tick_en),
        .vel_target(vel_target), .ctrl_tick(ctrl_tick), .pos_cmd_velocity(pos_cmd_velocity));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50)
        begin
            bad_count++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        chk(d, x, "read data");
        chk({31'h0, e}, 32'h0, "read error flag");
    endtask : rdchk

    // Exactly n ticks from the host model, then one edge so results settle
    task automatic ticks(input int n);
        int got;
        int lim;
        got = 0;
        lim = 0;
        tick_en <= 1'b1;
        while (got < n && lim < 2000)
        begin
            @(posedge pclk);
            lim++;
            if (ctrl_tick === 1'b1)
                got++;
        end
        tick_en <= 1'b0;
        if (got < n)
        begin
            bad_count++;
            conclude();
        end
        @(posedge pclk);
    endtask : ticks

    task automatic s_regs();
        logic [15:0] rv [9];
        logic [31:0] d;
        logic e;
        rv = '{VFF_GAIN_RST, VFF_FILT_RST, TFF_GAIN_RST, TFF_FILT_RST, ATFF_GAIN_RST,
               FUNC_EXP_RST, CTRL_MODE_RST, AUTOTUNE_RST, INERTIA_RST};
        for (int i = 0; i < 9; i++)
            rdchk(8'(4 * i), {16'h0, rv[i]});
        apb(1'b0, 8'h28, 32'h0, d, e);
        chk({31'h0, e}, 32'h1, "unmapped read error");
        chk(d, 32'h0, "unmapped read data");
        wr(STATUS_OFS, 32'h0000000e);
        rdchk(STATUS_OFS, 32'h00000000);
        wr(VFF_FILT_OFS, 32'hffff0123);
        rdchk(VFF_FILT_OFS, 32'h00000123);
        wr(VFF_FILT_OFS, 32'h0);
    endtask : s_regs

    task automatic s_vff();
        logic [15:0] md [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h3};
        logic [31:0] a;
        logic [31:0] b;
        wr(VFF_GAIN_OFS, 32'h1f4);
        vel_target <= 24'h3e8;
        pos_loop_speed <= 24'h32;
        for (int i = 0; i < 8; i++)
        begin
            mode_second_sel <= (i == 7);
            wr(CTRL_MODE_OFS, {16'h0, md[i]});
            ticks(3);
            chk(speed_cmd_q, (i inside {0, 3, 4, 6}) ? 32'h226 : 32'h32, "mode gate");
        end
        mode_second_sel <= 1'b0;
        wr(CTRL_MODE_OFS, 32'h0);
        wr(VFF_GAIN_OFS, 32'h7d0);
        ticks(3);
        chk(speed_cmd_q, 32'h41a, "gain clip");
        wr(VFF_GAIN_OFS, 32'h3e8);
        vel_target <= 24'h0;
        ticks(2);
        wr(VFF_FILT_OFS, 32'h32);
        vel_target <= 24'hc80;
        ticks(1);
        a = speed_cmd_q;
        ticks(1);
        b = speed_cmd_q;
        chk((a == 32'h32 && b == 32'h96) || (a == 32'h96 && b == 32'hf6), 1, "lag step");
        ticks(300);
        chk(speed_cmd_q inside {[32'hc93:32'hcb2]}, 1, "lag settle");
        rdchk(STATUS_OFS, 32'h00000001);
        wr(VFF_GAIN_OFS, 32'h0);
        vel_target <= 24'h0;
    endtask : s_vff

    task automatic s_tff();
        wr(TFF_GAIN_OFS, 32'h3e8);
        vel_cmd_torque <= 24'hc8;
        vel_loop_torque <= 16'h64;
        ticks(3);
        chk(torque_cmd_q, 32'h12c, "torque ff full");
        wr(TFF_GAIN_OFS, 32'h1f4);
        ticks(3);
        chk(torque_cmd_q, 32'hc8, "torque ff half");
        wr(TFF_GAIN_OFS, 32'h3e8);
        vel_cmd_torque <= 24'h1f4;
        vel_loop_torque <= 16'hb54;
        ticks(3);
        chk(torque_cmd_q, 32'hbb8, "torque high clip");
        rdchk(STATUS_OFS, 32'h00000009);
        vel_cmd_torque <= -24'sh1f4;
        vel_loop_torque <= -16'shb54;
        ticks(3);
        chk(torque_cmd_q, -32'shbb8, "torque low clip");
        vel_cmd_torque <= 24'h0;
        vel_loop_torque <= 16'h0;
        ticks(2);
        wr(TFF_FILT_OFS, 32'h32);
        vel_cmd_torque <= 24'hc80;
        ticks(1);
        chk(torque_cmd_q inside {32'h0, 32'h64}, 1, "torque lag step");
        wr(TFF_GAIN_OFS, 32'h0);
        vel_cmd_torque <= 24'h0;
        ticks(3);
    endtask : s_tff

    // Conversion gain, enable bit, polarity and input sharing
    task automatic s_atff();
        logic [15:0] g [6] = '{16'h1e, 16'h1e, 16'h0a, 16'h09, 16'h1e, 16'h1e};
        logic [15:0] fx [6] = '{16'h20, 16'h20, 16'h20, 16'h20, 16'h00, 16'h20};
        logic signed [15:0] mv [6] = '{16'hbb8, -16'shbb8, 16'hbb8, 16'hbb8, 16'hbb8, 16'hbb8};
        logic signed [31:0] ex [6] = '{32'h3e8, -32'sh3e8, 32'hbb8, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++)
        begin
            ain3_other_use <= (i == 5);
            ain3_mv <= mv[i];
            wr(ATFF_GAIN_OFS, {16'h0, g[i]});
            wr(FUNC_EXP_OFS, {16'h0, fx[i]});
            ticks(3);
            chk(torque_cmd_q, ex[i], "analog torque");
        end
        ain3_other_use <= 1'b0;
        ain3_mv <= 16'h0;
        wr(FUNC_EXP_OFS, 32'h0);
        ticks(3);
    endtask : s_atff

    task automatic s_obs();
        logic [15:0] md [7] = '{16'h0, 16'h1, 16'h6, 16'h3, 16'h0, 16'h0, 16'h0};
        logic [15:0] at [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h0, 16'h0};
        logic [15:0] fx [7] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h0, 16'h1};
        logic so [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic ex [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 7; i++)
        begin
            servo_on <= so[i];
            wr(CTRL_MODE_OFS, {16'h0, md[i]});
            wr(AUTOTUNE_OFS, {16'h0, at[i]});
            wr(FUNC_EXP_OFS, {16'h0, fx[i]});
            repeat (3) @(posedge pclk);
            chk({31'h0, observer_active}, {31'h0, ex[i]}, "observer gate");
        end
        measured_speed <= 24'h309;
        ticks(2);
        chk(speed_est_q, 32'h309, "estimate follows");
        servo_on <= 1'b1;
        repeat (3) @(posedge pclk);
        measured_speed <= 24'h629;
        ticks(1);
        chk(speed_est_q, 32'h36d, "observer step");
    endtask : s_obs

    // Reset, then every scenario in turn
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_regs();
        s_vff();
        s_tff();
        s_atff();
        s_obs();
        conclude();
    end
endmodule : tb_sffp_top
